// *** pomc_mode_ctrl.sv ***
`timescale 1ns/1ps

module pomc_mode_ctrl #(
  parameter int unsigned GREEN_MIN_CYC   = pomc_pkg::GREEN_MIN_CYC,
  parameter int unsigned PWRON_BLINK_CYC = pomc_pkg::PWRON_BLINK_CYC,
  parameter int unsigned BLINK_HALF_CYC  = pomc_pkg::BLINK_HALF_CYC,
  parameter int unsigned HOLD_HALF_CYC   = pomc_pkg::HOLD_HALF_CYC
) (
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  input  wire logic                       run_request,
  input  wire logic                       stop_request,
  input  wire pomc_pkg::pomc_exec_status_t exec_status,
  output pomc_pkg::pomc_exec_ctrl_t       exec_ctrl,
  output pomc_pkg::pomc_leds_t            leds,
  output pomc_pkg::pomc_mode_t            mode,
  output logic                            output_disable_lock,
  output logic                            watchdog_latched
);

  // ==========================================================================
  // state
  pomc_pkg::pomc_mode_t mode_reg;
  pomc_pkg::pomc_mode_t mode_next;
  logic [31:0]          green_cnt_reg;
  logic [31:0]          pwron_cnt_reg;
  logic                 wd_reg;
  logic                 trig_pending_reg;
  logic                 fast_wave;
  logic                 hold_wave;

  localparam logic [31:0] GMIN = 32'(GREEN_MIN_CYC);
  localparam logic [31:0] PMIN = 32'(PWRON_BLINK_CYC);

  pomc_blinker #(.HALF_CYC(32'(BLINK_HALF_CYC))) u_fast (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wave    (fast_wave)
  );

  pomc_blinker #(.HALF_CYC(32'(HOLD_HALF_CYC))) u_hold (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wave    (hold_wave)
  );

  // ==========================================================================
  // decode
  wire is_stop    = (mode_reg == pomc_pkg::POMC_STOP);
  wire is_startup = (mode_reg == pomc_pkg::POMC_STARTUP);
  wire is_run     = (mode_reg == pomc_pkg::POMC_RUN);
  wire is_hold    = (mode_reg == pomc_pkg::POMC_HOLD);
  wire green_busy = (green_cnt_reg != 32'h0);
  wire pwron_busy = (pwron_cnt_reg != 32'h0);
  wire any_error  = exec_status.error | exec_status.watchdog_error;
  // a cold start is the only way out once the watchdog has fired
  wire go_startup = is_stop & run_request & ~stop_request;

  // no timer guards START-UP: only done, error or a stop request can leave it
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      pomc_pkg::POMC_STOP: begin
        if (go_startup) begin
          mode_next = pomc_pkg::POMC_STARTUP;
        end
      end
      pomc_pkg::POMC_STARTUP: begin
        if (any_error | stop_request) begin
          mode_next = pomc_pkg::POMC_STOP;
        end else if (exec_status.done_pulse) begin
          mode_next = pomc_pkg::POMC_RUN;
        end
      end
      pomc_pkg::POMC_RUN: begin
        if (any_error | stop_request) begin
          mode_next = pomc_pkg::POMC_STOP;
        end else if (exec_status.breakpoint_hit) begin
          mode_next = pomc_pkg::POMC_HOLD;
        end
      end
      pomc_pkg::POMC_HOLD: begin
        if (any_error | stop_request) begin
          mode_next = pomc_pkg::POMC_STOP;
        end else if (exec_status.resume) begin
          mode_next = pomc_pkg::POMC_RUN;
        end
      end
      default: mode_next = pomc_pkg::POMC_STOP;
    endcase
  end

  // ==========================================================================
  // mode register and counters
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_reg <= pomc_pkg::POMC_STOP;
    end else begin
      mode_reg <= mode_next;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wd_reg <= 1'b0;
    end else if (exec_status.watchdog_error) begin
      wd_reg <= 1'b1;
    end else if (is_startup & exec_status.done_pulse) begin
      wd_reg <= 1'b0;
    end
  end

  // handler trigger waits one cycle in START-UP so it appears in the same cycle as the registered mode output
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      trig_pending_reg <= 1'b0;
    end else begin
      trig_pending_reg <= go_startup;
    end
  end

  // the minimum keeps running through STOP and RUN once begun
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      green_cnt_reg <= 32'h0;
    end else if (is_startup & exec_status.begin_pulse) begin
      green_cnt_reg <= GMIN;
    end else if (green_busy) begin
      green_cnt_reg <= green_cnt_reg - 32'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pwron_cnt_reg <= PMIN;
    end else if (pwron_busy) begin
      pwron_cnt_reg <= pwron_cnt_reg - 32'h1;
    end
  end

  // ==========================================================================
  // outputs, all registered
  wire lock_next   = ~is_run;
  wire yellow_next = is_stop & (pwron_busy ? fast_wave : 1'b1);
  wire green_next  = green_busy ? fast_wave :
                     is_hold ? hold_wave :
                     is_run;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      output_disable_lock <= 1'b1;
      leds                <= '0;
      exec_ctrl           <= '0;
      mode                <= pomc_pkg::POMC_STOP;
      watchdog_latched    <= 1'b0;
    end else begin
      output_disable_lock          <= lock_next;
      leds.yellow                  <= yellow_next;
      leds.green                   <= green_next;
      leds.red                     <= is_hold;
      // counters, timers and image are never reset by a move to STOP
      exec_ctrl.run_enable         <= is_run | is_startup;
      exec_ctrl.timers_frozen      <= ~is_run;
      exec_ctrl.restart_trigger    <= trig_pending_reg & ~wd_reg;
      exec_ctrl.cold_start_trigger <= trig_pending_reg & wd_reg;
      mode                         <= mode_reg;
      watchdog_latched             <= wd_reg;
    end
  end

  // ==========================================================================
  // checks
  property p_lock_stop;
    @(posedge sys_clk) disable iff (rst)
      is_stop |=> output_disable_lock;
  endproperty
  a_lock_stop: assert property (p_lock_stop) else $error("lock low in stop");

  property p_lock_startup;
    @(posedge sys_clk) disable iff (rst)
      is_startup |=> output_disable_lock;
  endproperty
  a_lock_startup: assert property (p_lock_startup) else $error("lock low in start-up");

  property p_lock_run;
    @(posedge sys_clk) disable iff (rst)
      is_run |=> !output_disable_lock;
  endproperty
  a_lock_run: assert property (p_lock_run) else $error("lock high in run");

  property p_no_exec_stop;
    @(posedge sys_clk) disable iff (rst)
      is_stop |=> !exec_ctrl.run_enable;
  endproperty
  a_no_exec_stop: assert property (p_no_exec_stop) else $error("executor runs in stop");

  property p_trigger;
    @(posedge sys_clk) disable iff (rst)
      go_startup |-> ##2 (exec_ctrl.restart_trigger | exec_ctrl.cold_start_trigger);
  endproperty
  a_trigger: assert property (p_trigger) else $error("no handler trigger");

  property p_green_min;
    @(posedge sys_clk) disable iff (rst)
      (is_startup & exec_status.begin_pulse) |=> green_busy [*8];
  endproperty
  a_green_min: assert property (p_green_min) else $error("green minimum cut short");

  property p_yellow_stop;
    @(posedge sys_clk) disable iff (rst)
      (is_stop & !pwron_busy) |=> leds.yellow;
  endproperty
  a_yellow_stop: assert property (p_yellow_stop) else $error("yellow not steady");

  property p_red_hold;
    @(posedge sys_clk) disable iff (rst)
      is_hold |=> (leds.red & output_disable_lock & exec_ctrl.timers_frozen);
  endproperty
  a_red_hold: assert property (p_red_hold) else $error("hold outputs wrong");

  property p_wd_cold;
    @(posedge sys_clk) disable iff (rst)
      (wd_reg & trig_pending_reg) |=> (exec_ctrl.cold_start_trigger & !exec_ctrl.restart_trigger);
  endproperty
  a_wd_cold: assert property (p_wd_cold) else $error("warm restart after watchdog");

  property p_green_run;
    @(posedge sys_clk) disable iff (rst)
      (is_run & !green_busy) |=> leds.green;
  endproperty
  a_green_run: assert property (p_green_run) else $error("green not steady in run");

endmodule : pomc_mode_ctrl

// *** pomc_pkg.sv ***
package pomc_pkg;

  // ==========================================================================
  // modes and timing
  typedef enum logic [1:0] {
    POMC_STOP    = 2'b00,
    POMC_STARTUP = 2'b01,
    POMC_RUN     = 2'b10,
    POMC_HOLD    = 2'b11
  } pomc_mode_t;

  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned GREEN_MIN_S     = 3;
  localparam int unsigned HOLD_BLINK_HZ   = 1;
  localparam int unsigned BLINK_HALF_MS   = 250;
  localparam int unsigned PWRON_BLINK_MS  = 2000;
  localparam int unsigned GREEN_MIN_CYC   = GREEN_MIN_S * CLK_HZ;
  localparam int unsigned HOLD_HALF_CYC   = CLK_HZ / (2 * HOLD_BLINK_HZ);
  localparam int unsigned BLINK_HALF_CYC  = (BLINK_HALF_MS * (CLK_HZ / 1000));
  localparam int unsigned PWRON_BLINK_CYC = (PWRON_BLINK_MS * (CLK_HZ / 1000));
  localparam int unsigned CNT_W           = 32;

  // ==========================================================================
  // executor handshake
  typedef struct packed {
    logic begin_pulse;
    logic done_pulse;
    logic error;
    logic watchdog_error;
    logic breakpoint_hit;
    logic resume;
  } pomc_exec_status_t;

  typedef struct packed {
    logic run_enable;
    logic restart_trigger;
    logic cold_start_trigger;
    logic timers_frozen;
  } pomc_exec_ctrl_t;

  typedef struct packed {
    logic yellow;
    logic green;
    logic red;
  } pomc_leds_t;

endpackage : pomc_pkg

// *** pomc_blinker.sv ***
`timescale 1ns/1ps

// ============================================================================
// free-running square wave with a programmable half period
module pomc_blinker #(
  parameter logic [31:0] HALF_CYC = 32'h0000_0001
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  output logic      wave
);

  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic        wrap;

  assign wrap     = (cnt_reg >= HALF_CYC - 32'h1);
  assign cnt_next = wrap ? 32'h0 : cnt_reg + 32'h1;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 32'h0;
      wave    <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      if (wrap) begin
        wave <= ~wave;
      end
    end
  end

endmodule : pomc_blinker

// *** pomc_exec_model.sv ***
`timescale 1ns/1ps

// ==========================================================================
// executor model: begins each handler call after dly cycles and finishes it after twice dly cycles
module pomc_exec_model (
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  input  wire pomc_pkg::pomc_exec_ctrl_t exec_ctrl,
  input  wire logic [7:0]                dly,
  input  wire logic [3:0]                faults,
  output pomc_pkg::pomc_exec_status_t    exec_status
);
  logic       bgn = 1'b0;
  logic       dn  = 1'b0;
  logic       act = 1'b0;
  logic [8:0] cnt = 9'h000;

  assign exec_status = {bgn, dn, faults};

  // a call cut off by STOP is dropped, like a real executor would
  always @(posedge sys_clk) begin
    #1;
    bgn = 1'b0;
    dn  = 1'b0;
    if (rst || !exec_ctrl.run_enable) act = 1'b0;
    if (exec_ctrl.restart_trigger || exec_ctrl.cold_start_trigger) begin
      act = 1'b1;
      cnt = 9'h000;
    end else if (act) begin
      cnt = cnt + 9'h001;
      bgn = (cnt == {1'b0, dly});
      dn  = (cnt == {dly, 1'b0});
      if (dn) act = 1'b0;
    end
  end
endmodule : pomc_exec_model

// *** tb.sv ***
`timescale 1ns/1ps

module tb;
  localparam int GMIN = 40;
  localparam int PWR  = 100;
  logic                        sys_clk      = 1'b0;
  logic                        rst          = 1'b1;
  logic                        run_request  = 1'b0;
  logic                        stop_request = 1'b0;
  logic [7:0]                  dly          = 8'h03;
  logic [3:0]                  faults       = 4'h0;
  pomc_pkg::pomc_exec_status_t exec_status;
  pomc_pkg::pomc_exec_ctrl_t   exec_ctrl;
  pomc_pkg::pomc_leds_t        leds;
  pomc_pkg::pomc_mode_t        mode;
  logic                        output_disable_lock;
  logic                        watchdog_latched;
  logic [1:0]                  tg;
  int                          err_total  = 0;
  int                          num_checks = 0;
  int                          t;

  always #5 sys_clk = ~sys_clk;

  pomc_mode_ctrl #(.GREEN_MIN_CYC(GMIN), .PWRON_BLINK_CYC(PWR), .BLINK_HALF_CYC(4),
    .HOLD_HALF_CYC(10)) u_pomc_mode_ctrl (.sys_clk(sys_clk), .rst(rst),
    .run_request(run_request), .stop_request(stop_request), .exec_status(exec_status),
    .exec_ctrl(exec_ctrl), .leds(leds), .mode(mode),
    .output_disable_lock(output_disable_lock), .watchdog_latched(watchdog_latched));

  pomc_exec_model u_pomc_exec_model (.sys_clk(sys_clk), .rst(rst), .exec_ctrl(exec_ctrl),
    .dly(dly), .faults(faults), .exec_status(exec_status));

  function automatic logic exp_lock(input pomc_pkg::pomc_mode_t m);
    return m != pomc_pkg::POMC_RUN;
  endfunction : exp_lock

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      err_total++;
    end
  endtask : chk

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run

  // bounded wait; running out counts as a mismatch and ends the run
  task automatic wait_mode(input pomc_pkg::pomc_mode_t m, input int lim);
    for (int i = 0; i < lim && mode !== m; i++) cyc(1);
    chk(mode, m);
    if (mode !== m) complete_run();
  endtask : wait_mode

  task automatic tog(input logic sel, input int n, output int cnt);
    logic g;
    cnt = 0;
    g = sel ? leds.yellow : leds.green;
    repeat (n) begin
      cyc(1);
      if ((sel ? leds.yellow : leds.green) !== g) cnt++;
      g = sel ? leds.yellow : leds.green;
    end
  endtask : tog

  task automatic pulse(input int b);
    faults[b] = 1'b1;
    cyc(1);
    faults[b] = 1'b0;
  endtask : pulse

  // returns {cold, warm} trigger seen after the request
  task automatic start(output logic [1:0] trig);
    run_request = 1'b1;
    cyc(1);
    run_request = 1'b0;
    trig = 2'b00;
    for (int i = 0; i < 4 && trig == 2'b00; i++) begin
      cyc(1);
      trig = {exec_ctrl.cold_start_trigger, exec_ctrl.restart_trigger};
    end
    // no handler call within the bound ends the run as a mismatch
    chk(trig != 2'b00, 1'b1);
    if (trig == 2'b00) complete_run();
  endtask : start

  initial begin
    t = $urandom(32'hf0da);
    cyc(20);
    rst = 1'b0;
    tog(1'b1, 20, t);
    chk(t != 0, 1);
    chk(output_disable_lock, 1);
    chk(exec_ctrl.run_enable, 0);
    cyc(PWR);
    tog(1'b1, 10, t);
    chk(t, 0);
    chk(leds.yellow, 1);
    $display("test power-on done");
    start(tg);
    chk(tg, 2'b01);
    chk(mode, pomc_pkg::POMC_STARTUP);
    chk(output_disable_lock, 1);
    chk(exec_ctrl.run_enable, 1);
    wait_mode(pomc_pkg::POMC_RUN, 20);
    tog(1'b0, 16, t);
    chk(t != 0, 1);
    chk(output_disable_lock, exp_lock(pomc_pkg::POMC_RUN));
    cyc(GMIN);
    tog(1'b0, 8, t);
    chk(t, 0);
    chk(leds.green, 1);
    $display("test warm start done");
    pulse(1);
    wait_mode(pomc_pkg::POMC_HOLD, 5);
    chk({leds.red, output_disable_lock, exec_ctrl.timers_frozen}, 3'h7);
    tog(1'b0, 24, t);
    chk(t != 0, 1);
    pulse(0);
    wait_mode(pomc_pkg::POMC_RUN, 5);
    chk(exec_ctrl.timers_frozen, 0);
    $display("test hold done");
    pulse(3);
    wait_mode(pomc_pkg::POMC_STOP, 5);
    chk({output_disable_lock, leds.yellow}, 2'h3);
    dly = 8'h14;
    start(tg);
    cyc(22);
    pulse(3);
    wait_mode(pomc_pkg::POMC_STOP, 5);
    tog(1'b0, 16, t);
    chk(t != 0, 1);
    $display("test error in start-up done");
    dly = 8'h03;
    start(tg);
    wait_mode(pomc_pkg::POMC_RUN, 20);
    pulse(2);
    wait_mode(pomc_pkg::POMC_STOP, 5);
    chk(watchdog_latched, 1);
    start(tg);
    chk(tg, 2'b10);
    wait_mode(pomc_pkg::POMC_RUN, 20);
    chk(watchdog_latched, 0);
    $display("test watchdog done");
    repeat (4) begin
      stop_request = 1'b1;
      cyc(1);
      stop_request = 1'b0;
      wait_mode(pomc_pkg::POMC_STOP, 5);
      dly = 8'($urandom_range(150, 1));
      start(tg);
      chk(tg, 2'b01);
      cyc(dly);
      chk(mode, pomc_pkg::POMC_STARTUP);
      wait_mode(pomc_pkg::POMC_RUN, 2 * dly + 10);
      chk(output_disable_lock, exp_lock(pomc_pkg::POMC_RUN));
    end
    $display("test random start-up done");
    complete_run();
  end
endmodule : tb
